// *** p9gp_port.sv ***
// Port block: 8-bit I/O port with direction/data registers and pin sharing
//
// Summary of operation
// - Direction bit 1 drives, 0 inputs
// - Direction register write-only, reads all ones
// - Reset or hardware standby clears direction
// - Software standby keeps direction and output data
// - Software standby returns peripheral pins to GPIO
// - Data read: latch for outputs, pin otherwise
// - Pin selection independent of controller mode
// - Bit 7 clock pin selected by mode, enables
// - Bit 7 GPIO direction follows own bit
// - Receive enable makes bit 6 serial input
// - Transmit enable makes bit 5 serial output
// - Timer compare-A enables drive bits 1, 0
//
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/10ps
module p9gp_port
    import p9gp_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Standby controls
    input wire logic hw_standby,
    input wire logic sw_standby,
    // Avalon-MM slave
    input wire logic [15:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [7:0] avs_writedata,
    output logic [7:0] avs_readdata,
    output logic avs_waitrequest,
    // Serial interface controls and signals
    input wire logic serial_sync_mode,
    input wire logic clock_enable_high,
    input wire logic clock_enable_low,
    input wire logic receive_enable,
    input wire logic transmit_enable,
    input wire logic serial_clock_out,
    input wire logic serial_tx_data,
    output logic serial_clock_in,
    output logic serial_rx_data,
    // Timer compare-A controls and outputs
    input wire logic t3_compare_a_output_enable,
    input wire logic t2_compare_a_output_enable,
    input wire logic timer3_compare_a_output,
    input wire logic timer2_compare_a_output,
    // Pins
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe
);

    // Software-visible registers
    logic [7:0] dir_ff;
    logic [7:0] data_ff;
    // Bus answer state
    p9gp_bus_e bus_ff;
    // Per-pin combinational choice
    logic [7:0] nxt_pin_out;
    logic [7:0] nxt_pin_oe;
    logic [7:0] pin_rd;
    p9gp_ck_e ck_sel;
    // Peripherals stand released in software standby
    logic per_on;

    assign per_on = ~sw_standby;

    // Request decode
    logic req;
    logic hit_dir;
    logic hit_data;
    // Answer cycle: writes land here, with the request still held
    logic ans_cyc;
    assign req = (avs_read | avs_write) && (bus_ff == P9GP_IDLE);
    assign hit_dir = avs_address == P9GP_DIR_OFS;
    assign hit_data = avs_address == P9GP_DATA_OFS;
    assign ans_cyc = bus_ff == P9GP_ACK;

    // Bus handshake: one wait cycle, answer on the second edge
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bus_ff <= P9GP_IDLE;
        end else begin
            case (bus_ff)
                P9GP_IDLE: begin
                    // Any access is taken in idle
                    if (avs_read | avs_write) begin
                        bus_ff <= P9GP_ACK;
                    end
                end
                P9GP_ACK: begin
                    // Answer lasts one cycle
                    bus_ff <= P9GP_IDLE;
                end
                default: begin
                    bus_ff <= P9GP_IDLE;
                end
            endcase
        end
    end

    // Waitrequest low only in the answer cycle
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
        end else begin
            // Low in the cycle after the take edge
            avs_waitrequest <= ~req;
        end
    end

    // Direction register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dir_ff <= P9GP_DIR_RST;
        end else if (hw_standby) begin
            dir_ff <= P9GP_DIR_RST;
        end else if (ans_cyc && avs_write && hit_dir) begin
            // Lands at the edge where waitrequest is seen low
            dir_ff <= avs_writedata;
        end
        // Software standby leaves it alone
    end

    // Data register latch, written for every bit
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            data_ff <= P9GP_DATA_RST;
        end else if (hw_standby) begin
            data_ff <= P9GP_DATA_RST;
        end else if (ans_cyc && avs_write && hit_data) begin
            // Lands at the edge where waitrequest is seen low
            data_ff <= avs_writedata;
        end
    end

    // Data read value: latch for outputs, live pin for inputs
    generate
        for (genvar i = 0; i < 8; i++) begin : g_rd
            assign pin_rd[i] = dir_ff[i] ? data_ff[i] : pin_in[i];
        end
    endgenerate

    // Read data captured with the request
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            avs_readdata <= 8'h00;
        end else if (req && avs_read) begin
            // Taken at the request edge, stands at the answer edge
            if (hit_dir) begin
                avs_readdata <= P9GP_DIR_READ;
            end else if (hit_data) begin
                avs_readdata <= pin_rd;
            end else begin
                avs_readdata <= 8'h00;
            end
        end
    end

    // Clock pin function from serial_sync_mode and the clock enables
    always_comb begin
        if (!per_on) begin
            ck_sel = P9GP_CK_GPIO;
        end else if (serial_sync_mode) begin
            ck_sel = clock_enable_high ? P9GP_CK_IN : P9GP_CK_OUT;
        end else if (clock_enable_high) begin
            // Asynchronous mode: high enable wins over low
            ck_sel = P9GP_CK_IN;
        end else if (clock_enable_low) begin
            ck_sel = P9GP_CK_OUT;
        end else begin
            ck_sel = P9GP_CK_GPIO;
        end
    end

    // Pin drivers: GPIO default then peripheral takeover
    always_comb begin
        nxt_pin_out = data_ff;
        nxt_pin_oe = dir_ff;
        // Bit 7 clock pin
        case (ck_sel)
            P9GP_CK_OUT: begin
                nxt_pin_out[P9GP_SCK_BIT] = serial_clock_out;
                nxt_pin_oe[P9GP_SCK_BIT] = 1'b1;
            end
            P9GP_CK_IN: begin
                nxt_pin_oe[P9GP_SCK_BIT] = 1'b0;
            end
            default: begin
                nxt_pin_oe[P9GP_SCK_BIT] = dir_ff[P9GP_SCK_BIT];
            end
        endcase
        // Bit 6 receive pin
        if (per_on && receive_enable) begin
            nxt_pin_oe[P9GP_RXD_BIT] = 1'b0;
        end
        // Bit 5 transmit pin
        if (per_on && transmit_enable) begin
            nxt_pin_out[P9GP_TXD_BIT] = serial_tx_data;
            nxt_pin_oe[P9GP_TXD_BIT] = 1'b1;
        end
        // Timer compare-A outputs
        if (per_on && t3_compare_a_output_enable) begin
            nxt_pin_out[P9GP_T3_BIT] = timer3_compare_a_output;
            nxt_pin_oe[P9GP_T3_BIT] = 1'b1;
        end
        // Bit 0 timer two compare-A
        if (per_on && t2_compare_a_output_enable) begin
            nxt_pin_out[P9GP_T2_BIT] = timer2_compare_a_output;
            nxt_pin_oe[P9GP_T2_BIT] = 1'b1;
        end
    end

    // Registered pin drive
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pin_out <= 8'h00;
            pin_oe <= 8'h00;
        end else begin
            pin_out <= nxt_pin_out;
            pin_oe <= nxt_pin_oe;
        end
    end

    // Registered peripheral inputs from the pins
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            serial_clock_in <= 1'b0;
            serial_rx_data <= 1'b0;
        end else begin
            // Copied every cycle, whatever the pin's function
            serial_clock_in <= pin_in[P9GP_SCK_BIT];
            serial_rx_data <= pin_in[P9GP_RXD_BIT];
        end
    end

    // Output checks; each looks one edge after its cause
    // Named steps of one register access: take, then answer
    sequence bus_take_s;
        (avs_read || avs_write) && bus_ff == P9GP_IDLE;
    endsequence
    sequence bus_answer_s;
        bus_ff == P9GP_ACK && !avs_waitrequest;
    endsequence

    // Every taken access is answered on the next edge
    bus_answer_a: assert property (@(posedge ref_clk) disable iff (rst)
        bus_take_s |=> bus_answer_s) else $error("access not answered");
    // Waitrequest low for one cycle only
    wait_pulse_a: assert property (@(posedge ref_clk) disable iff (rst)
        bus_answer_s |=> avs_waitrequest) else $error("waitrequest low too long");
    // Read data stands through the answer cycle
    rd_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
        bus_answer_s |=> $stable(avs_readdata)) else $error("read data moved");
    // Direction read returns all ones
    dir_read_a: assert property (@(posedge ref_clk) disable iff (rst)
        (req && avs_read && hit_dir) |=> avs_readdata == 8'hff && !avs_waitrequest)
        else $error("direction read not ones");
    // Unmapped places read as zero
    rd_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
        (req && avs_read && !hit_dir && !hit_data) |=> avs_readdata == 8'h00)
        else $error("unmapped read not zero");

    // Direction cleared one edge after hardware standby
    dir_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
        hw_standby |=> dir_ff == 8'h00) else $error("direction not cleared");
    // Hardware standby also clears the latch
    data_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
        hw_standby |=> data_ff == 8'h00) else $error("data latch not cleared");
    // Software standby keeps direction
    sw_keep_a: assert property (@(posedge ref_clk) disable iff (rst)
        (sw_standby && !hw_standby && !(ans_cyc && avs_write)) |=> $stable(dir_ff))
        else $error("direction changed in standby");
    // Standby pins follow registers
    sw_pins_a: assert property (@(posedge ref_clk) disable iff (rst)
        sw_standby |=> pin_oe == $past(dir_ff) && pin_out == $past(data_ff))
        else $error("standby pin not gpio");
    // Pins without takeover follow direction and latch
    plain_pins_a: assert property (@(posedge ref_clk) disable iff (rst)
        1'b1 |=> pin_oe[4:2] == $past(dir_ff[4:2]) && pin_out[4:2] == $past(data_ff[4:2]))
        else $error("plain pin wrong");
    // Data write lands in the latch whatever the direction
    data_write_a: assert property (@(posedge ref_clk) disable iff (rst)
        (ans_cyc && avs_write && hit_data && !hw_standby) |=> data_ff == $past(avs_writedata))
        else $error("data latch not written");

    // Data read from output latch
    data_read_a: assert property (@(posedge ref_clk) disable iff (rst)
        (req && avs_read && hit_data && dir_ff[0]) |=> avs_readdata[0] == $past(data_ff[0]))
        else $error("data read wrong");
    // Data read of an input pin shows the pin
    pin_read_a: assert property (@(posedge ref_clk) disable iff (rst)
        (req && avs_read && hit_data && !dir_ff[7]) |=> avs_readdata[7] == $past(pin_in[7]))
        else $error("input pin read wrong");

    // Clock input mode releases bit 7
    ck_in_a: assert property (@(posedge ref_clk) disable iff (rst)
        (clock_enable_high && !sw_standby) |=> !pin_oe[7]) else $error("clock pin driven");
    // Clock output mode drives bit 7
    ck_out_a: assert property (@(posedge ref_clk) disable iff (rst)
        (!sw_standby && !clock_enable_high && (serial_sync_mode || clock_enable_low)) |=>
        pin_oe[7] && pin_out[7] == $past(serial_clock_out))
        else $error("clock pin not driven");
    // Clock pin as plain I/O follows its own bit
    ck_gpio_a: assert property (@(posedge ref_clk) disable iff (rst)
        (sw_standby || !(serial_sync_mode || clock_enable_high || clock_enable_low)) |=>
        pin_oe[7] == $past(dir_ff[7])) else $error("clock pin not gpio");

    // Receive pin is input
    rx_input_a: assert property (@(posedge ref_clk) disable iff (rst)
        (receive_enable && !sw_standby) |=> !pin_oe[6]) else $error("receive pin driven");
    // Receive data copies the pin
    rx_data_a: assert property (@(posedge ref_clk) disable iff (rst)
        1'b1 |=> serial_rx_data == $past(pin_in[6])) else $error("receive data wrong");
    // Receive pin as plain I/O when disabled
    rx_gpio_a: assert property (@(posedge ref_clk) disable iff (rst)
        (!receive_enable || sw_standby) |=> pin_oe[6] == $past(dir_ff[6]))
        else $error("receive pin not gpio");
    // Transmit pin drives serial data
    tx_drive_a: assert property (@(posedge ref_clk) disable iff (rst)
        (transmit_enable && !sw_standby) |=> pin_oe[5] && pin_out[5] == $past(serial_tx_data))
        else $error("transmit pin not driven");
    // Transmit pin as plain I/O when disabled
    tx_gpio_a: assert property (@(posedge ref_clk) disable iff (rst)
        (!transmit_enable || sw_standby) |=> pin_oe[5] == $past(dir_ff[5]))
        else $error("transmit pin not gpio");

    // Timer three output
    t3_drive_a: assert property (@(posedge ref_clk) disable iff (rst)
        (t3_compare_a_output_enable && !sw_standby) |=>
        pin_oe[1] && pin_out[1] == $past(timer3_compare_a_output))
        else $error("timer pin not driven");
    // Timer two output
    t2_drive_a: assert property (@(posedge ref_clk) disable iff (rst)
        (t2_compare_a_output_enable && !sw_standby) |=>
        pin_oe[0] && pin_out[0] == $past(timer2_compare_a_output))
        else $error("timer two pin not driven");
    // Timer pins as plain I/O when disabled
    tmr_gpio_a: assert property (@(posedge ref_clk) disable iff (rst)
        (!(t3_compare_a_output_enable || t2_compare_a_output_enable) || sw_standby) |=>
        pin_oe[1:0] == $past(dir_ff[1:0])) else $error("timer pins not gpio");

endmodule // p9gp_port

// *** p9gp_pkg.sv ***
// Package: register map, reset values and pin selection constants for the port block
package p9gp_pkg;
    // Register offsets (byte addresses)
    localparam logic [15:0] P9GP_DIR_OFS = 16'hfefe;
    localparam logic [15:0] P9GP_DATA_OFS = 16'hfeff;
    // Reset values
    localparam logic [7:0] P9GP_DIR_RST = 8'h00;
    localparam logic [7:0] P9GP_DATA_RST = 8'h00;
    // Value returned when the direction register is read
    localparam logic [7:0] P9GP_DIR_READ = 8'hff;
    // Pin positions
    localparam int P9GP_SCK_BIT = 7;
    localparam int P9GP_RXD_BIT = 6;
    localparam int P9GP_TXD_BIT = 5;
    localparam int P9GP_T3_BIT = 1;
    localparam int P9GP_T2_BIT = 0;
    // Clock pin functions
    typedef enum logic [1:0] {
        P9GP_CK_GPIO = 2'b00,
        P9GP_CK_OUT = 2'b01,
        P9GP_CK_IN = 2'b11
    } p9gp_ck_e;
    // Bus answer states, Gray coded
    typedef enum logic [1:0] {
        P9GP_IDLE = 2'b00,
        P9GP_ACK = 2'b01
    } p9gp_bus_e;
endpackage

// *** p9gp_ext_model.sv ***
// External circuitry model that drives the port pins
`timescale 1ns/10ps
module p9gp_ext_model (
    // Device pin side
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    // Level the outside world applies
    input wire logic [7:0] ext_val,
    output logic [7:0] pin_in
);
    // Driven pins read back the device level, released pins the outside level
    always_comb begin
        pin_in = (pin_out & pin_oe) | (ext_val & ~pin_oe);
    end
endmodule // p9gp_ext_model

// *** p9gp_port_tb_top.sv ***
// Self-checking testbench for the port block
`timescale 1ns/10ps
module p9gp_port_tb_top;
    import p9gp_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic hw_standby = 1'b0;
    logic [15:0] avs_address = 16'h0000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [7:0] avs_writedata = 8'h00;
    logic [7:0] avs_readdata;
    logic avs_waitrequest;
    // Control bits: 11 sw standby, 10 sync, 9..8 clock enables, 7 receive, 6 transmit,
    // 5..4 timer enables, 3 serial clock, 2 tx data, 1..0 timer outputs
    logic [11:0] ctl = 12'h000;
    logic [7:0] ext = 8'h00;
    logic [7:0] pin_in, pin_out, pin_oe, rd;
    logic serial_clock_in, serial_rx_data;
    int error_cnt = 0;
    int total_checks = 0;
    int dir_m = 0;
    int dat_m = 0;
    integer seed = 32'h144f;
    // Clock of 10 ns period
    always #5 ref_clk = ~ref_clk;
    p9gp_port dut_u (.ref_clk(ref_clk), .rst(rst), .hw_standby(hw_standby),
        .sw_standby(ctl[11]), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .serial_sync_mode(ctl[10]),
        .clock_enable_high(ctl[9]), .clock_enable_low(ctl[8]), .receive_enable(ctl[7]),
        .transmit_enable(ctl[6]), .serial_clock_out(ctl[3]), .serial_tx_data(ctl[2]),
        .serial_clock_in(serial_clock_in), .serial_rx_data(serial_rx_data),
        .t3_compare_a_output_enable(ctl[5]), .t2_compare_a_output_enable(ctl[4]),
        .timer3_compare_a_output(ctl[1]), .timer2_compare_a_output(ctl[0]),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
    p9gp_ext_model ext_u (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext), .pin_in(pin_in));
    // Compare and count
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // One Avalon access, held until waitrequest is sampled low
    task bus(input logic wr, input logic [15:0] adr, input logic [7:0] wd);
        @(posedge ref_clk);
        avs_address <= adr;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (wr && adr == P9GP_DIR_OFS) dir_m = wd;
        if (wr && adr == P9GP_DATA_OFS) dat_m = wd;
    endtask
    // Expected pin drive from the model registers and control bits
    task pins_chk;
        logic [7:0] oe;
        logic [7:0] out;
        repeat (3) @(posedge ref_clk);
        oe = 8'(dir_m);
        out = 8'(dat_m);
        // Peripherals own pins only outside software standby
        if (!ctl[11]) begin
            if (ctl[10] ? !ctl[9] : (ctl[9:8] == 2'b01)) begin
                oe[7] = 1'b1;
                out[7] = ctl[3];
            end else if (ctl[10] || ctl[9]) oe[7] = 1'b0;
            if (ctl[7]) oe[6] = 1'b0;
            if (ctl[6]) begin
                oe[5] = 1'b1;
                out[5] = ctl[2];
            end
            if (ctl[5]) {oe[1], out[1]} = {1'b1, ctl[1]};
            if (ctl[4]) {oe[0], out[0]} = {1'b1, ctl[0]};
        end
        chk(pin_oe, oe);
        chk(pin_out & oe, out & oe);
        chk({6'h00, serial_clock_in, serial_rx_data}, {6'h00, pin_in[7:6]});
    endtask
    // Verdict and end of run
    task test_done;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (20000) @(posedge ref_clk);
        error_cnt++;
        test_done;
    end
    // Main sequence
    initial begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        ext <= 8'($random(seed));
        bus(1'b0, P9GP_DATA_OFS, 8'h00);
        chk(rd, ext);
        // Plain I/O with random direction, data and outside levels
        for (int i = 0; i < 8; i++) begin
            ext <= 8'($random(seed));
            bus(1'b1, P9GP_DIR_OFS, 8'($random(seed)));
            bus(1'b1, P9GP_DATA_OFS, 8'($random(seed)));
            bus(1'b0, P9GP_DATA_OFS, 8'h00);
            chk(rd, 8'((dat_m & dir_m) | (ext & ~dir_m)));
            bus(1'b0, P9GP_DIR_OFS, 8'h00);
            chk(rd, P9GP_DIR_READ);
            pins_chk;
        end
        // Latch written while input shows once the pin drives
        bus(1'b1, P9GP_DIR_OFS, 8'h00);
        bus(1'b1, P9GP_DATA_OFS, 8'($random(seed)));
        bus(1'b1, P9GP_DIR_OFS, 8'hff);
        pins_chk;
        // Unmapped place reads zero and ignores writes
        bus(1'b1, 16'hfefd, 8'h5a);
        bus(1'b0, 16'hfefd, 8'h00);
        chk(rd, 8'h00);
        // Random peripheral takeover, standby included
        for (int i = 0; i < 48; i++) begin
            ctl <= 12'($random(seed));
            pins_chk;
        end
        // Hardware standby clears the registers
        ctl <= 12'h000;
        hw_standby <= 1'b1;
        repeat (2) @(posedge ref_clk);
        hw_standby <= 1'b0;
        dir_m = 0;
        dat_m = 0;
        pins_chk;
        bus(1'b0, P9GP_DATA_OFS, 8'h00);
        chk(rd, ext);
        test_done;
    end
endmodule // p9gp_port_tb_top
